// ===== shared/thocr_defines.vh
// Constants for the thermal hysteresis / offset / config register group.
// Assumes an 8-bit register bus with 8-bit offsets, as seen behind the SMBus slave.
`ifndef THOCR_DEFINES_VH
`define THOCR_DEFINES_VH

`define THOCR_ADDR_HYST_R1L       8'h6d
`define THOCR_ADDR_HYST_R2        8'h6e
`define THOCR_ADDR_TREE_TEST      8'h6f
`define THOCR_ADDR_OFS_R1         8'h70
`define THOCR_ADDR_OFS_LOCAL      8'h71
`define THOCR_ADDR_OFS_R2         8'h72
`define THOCR_ADDR_CONFIG2        8'h73

`define THOCR_RST_HYST_R1L        8'h44
`define THOCR_RST_HYST_R2         8'h40
`define THOCR_RST_TREE_TEST       8'h00
`define THOCR_RST_OFS             8'h00
`define THOCR_RST_CONFIG2         8'h00

`define THOCR_LOCAL_HYST_LSB      0
`define THOCR_LOCAL_HYST_MSB      3
`define THOCR_REMOTE_HYST_LSB     4
`define THOCR_REMOTE_HYST_MSB     7
`define THOCR_TREE_BIT            0
`define THOCR_SENSE_LSB           0
`define THOCR_SENSE_MSB           3
`define THOCR_AVG_OFF_BIT         4

// Temperature codes: 8-bit unsigned, one LSB = 0.5 degree
`define THOCR_TEMP_MAX            8'hff
`define THOCR_TEMP_MIN            8'h00

`endif

// ===== rtl/thocr_offset_add.v
// Adds a signed half-degree offset to a raw temperature code, saturating.
// Assumes raw and offset use the same 0.5 degree LSB.
`timescale 1ns/1ps
`include "thocr_defines.vh"

module thocr_offset_add (
    input  wire [7:0] raw_temp,
    input  wire [7:0] offset,
    output reg  [7:0] corrected_temp
);
    reg [9:0] sum;

    // Sign-extend offset; clamp so a large negative offset cannot wrap to hot
    always @* begin
        sum = {2'b00, raw_temp} + {{2{offset[7]}}, offset};
        if (sum[9])
            corrected_temp = `THOCR_TEMP_MIN;
        else if (sum[8])
            corrected_temp = `THOCR_TEMP_MAX;
        else
            corrected_temp = sum[7:0];
    end
endmodule // thocr_offset_add

// ===== rtl/thocr_hyst_loop.v
// One channel's hysteresis comparators for fan-start and critical limits.
// Assumes temperatures and limits share one code; hysteresis is in whole degrees.
`timescale 1ns/1ps
`include "thocr_defines.vh"

module thocr_hyst_loop (
    input  wire       clock,
    input  wire       rst,
    input  wire       clock_enable,
    input  wire       sample_valid,
    input  wire [7:0] temp,
    input  wire [7:0] start_limit,
    input  wire [7:0] crit_limit,
    input  wire [3:0] hyst,
    output reg        fan_active,
    output reg        crit_active
);
    reg [8:0] start_release;
    reg [8:0] crit_release;

    // Hysteresis in degrees is two LSBs each; bit 8 set marks a release point below zero
    always @* begin
        start_release = {1'b0, start_limit} - {4'b0000, hyst, 1'b0};
        crit_release  = {1'b0, crit_limit} - {4'b0000, hyst, 1'b0};
    end

    // Set above the limit; fan-start releases at or below limit less hysteresis, critical only below it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            fan_active  <= 1'b0;
            crit_active <= 1'b0;
        end else if (clock_enable && sample_valid) begin
            if (temp > start_limit)
                fan_active <= 1'b1;
            // A release point below zero is floored, so only a zero reading releases
            else if (start_release[8] ? (temp == `THOCR_TEMP_MIN)
                                      : ({1'b0, temp} <= start_release))
                fan_active <= 1'b0; // [RULE13]
            if (temp > crit_limit)
                crit_active <= 1'b1;
            else if (!crit_release[8] && ({1'b0, temp} < crit_release))
                crit_active <= 1'b0; // [RULE14]
        end
    end
endmodule // thocr_hyst_loop

// ===== rtl/thocr_regs.v
// Hysteresis, temperature offset, tree test and fan-sense config registers.
// Assumes a byte register port from the serial bus slave on the same clock;
// raw temperatures and limits come from the converter and limit registers.
//
// Function
// (RULE1) Local hysteresis in bits 3..0
// (RULE2) Remote 1 hysteresis in bits 7..4
// (RULE3) Remote 2 hysteresis in bits 7..4
// (RULE4) Lock makes whole group read-only
// (RULE5) Bit 0 enables tree test mode
// (RULE6) Host leaves tree bits 7..1 unwritten
// (RULE7) Signed half-degree offset on remote 1
// (RULE8) Signed half-degree offset on local
// (RULE9) Signed half-degree offset on remote 2
// (RULE10) Per-input bit selects two-wire sensing
// (RULE11) Two-wire sensing only in low-frequency drive
// (RULE12) Bit 4 turns measurement averaging off
// (RULE13) Fan-start release at limit minus hysteresis
// (RULE14) Critical release below limit minus hysteresis
// (RULE15) Config register at 0x73, resets zero
// (RULE16) Corrected temperature feeds readback and loops
`timescale 1ns/1ps
`include "thocr_defines.vh"

module thocr_regs (
    input  wire       clock,
    input  wire       rst,
    input  wire       clock_enable,
    input  wire       lock,
    input  wire       low_freq_mode,
    input  wire       reg_write,
    input  wire       reg_read,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_hit,
    input  wire       sample_valid,
    input  wire [7:0] raw_remote_one,
    input  wire [7:0] raw_local,
    input  wire [7:0] raw_remote_two,
    input  wire [7:0] start_remote_one,
    input  wire [7:0] start_local,
    input  wire [7:0] start_remote_two,
    input  wire [7:0] crit_remote_one,
    input  wire [7:0] crit_local,
    input  wire [7:0] crit_remote_two,
    output reg  [7:0] temp_remote_one,
    output reg  [7:0] temp_local,
    output reg  [7:0] temp_remote_two,
    output reg  [2:0] fan_active,
    output reg  [2:0] crit_active,
    output reg        tree_test_mode,
    output reg  [3:0] two_wire_sense_en,
    output reg        averaging_off
);
    reg  [7:0] remote_one_local_hysteresis;
    reg  [7:0] remote_two_hysteresis;
    reg        tree_test_enable_bit;
    reg  [7:0] remote_one_temp_offset;
    reg  [7:0] local_temp_offset;
    reg  [7:0] remote_two_temp_offset;
    reg  [7:0] fan_sense_averaging_config;
    reg  [7:0] next_rdata;
    reg        next_hit;
    wire [7:0] corr_remote_one;
    wire [7:0] corr_local;
    wire [7:0] corr_remote_two;
    wire [2:0] loop_fan;
    wire [2:0] loop_crit;
    wire [3:0] local_hyst_field;
    wire [3:0] remote_one_hyst_field;
    wire [3:0] remote_two_hyst_field;

    // Field views of the hysteresis registers
    assign local_hyst_field      = remote_one_local_hysteresis[`THOCR_LOCAL_HYST_MSB:`THOCR_LOCAL_HYST_LSB]; // [RULE1]
    assign remote_one_hyst_field = remote_one_local_hysteresis[`THOCR_REMOTE_HYST_MSB:`THOCR_REMOTE_HYST_LSB]; // [RULE2]
    assign remote_two_hyst_field = remote_two_hysteresis[`THOCR_REMOTE_HYST_MSB:`THOCR_REMOTE_HYST_LSB]; // [RULE3]

    // True when a write to the given offset is allowed to land
    function wr_ok;
        input [7:0] addr;
        input [7:0] target;
        input       wr;
        input       locked;
        begin
            wr_ok = wr && !locked && (addr == target); // [RULE4]
        end
    endfunction

    // Register writes; a locked device ignores every write in the group
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            remote_one_local_hysteresis <= `THOCR_RST_HYST_R1L;
            remote_two_hysteresis       <= `THOCR_RST_HYST_R2;
            tree_test_enable_bit        <= 1'b0;
            remote_one_temp_offset      <= `THOCR_RST_OFS;
            local_temp_offset           <= `THOCR_RST_OFS;
            remote_two_temp_offset      <= `THOCR_RST_OFS;
            fan_sense_averaging_config  <= `THOCR_RST_CONFIG2; // [RULE15]
        end else if (clock_enable) begin
            if (wr_ok(reg_addr, `THOCR_ADDR_HYST_R1L, reg_write, lock))
                remote_one_local_hysteresis <= reg_wdata;
            // Low nibble has no function here, kept at zero
            if (wr_ok(reg_addr, `THOCR_ADDR_HYST_R2, reg_write, lock))
                remote_two_hysteresis <= {reg_wdata[7:4], 4'h0}; // [RULE3]
            // Upper bits are read-only, so a stray write cannot set them
            if (wr_ok(reg_addr, `THOCR_ADDR_TREE_TEST, reg_write, lock))
                tree_test_enable_bit <= reg_wdata[`THOCR_TREE_BIT]; // [RULE5] [RULE6]
            if (wr_ok(reg_addr, `THOCR_ADDR_OFS_R1, reg_write, lock))
                remote_one_temp_offset <= reg_wdata; // [RULE7]
            if (wr_ok(reg_addr, `THOCR_ADDR_OFS_LOCAL, reg_write, lock))
                local_temp_offset <= reg_wdata; // [RULE8]
            if (wr_ok(reg_addr, `THOCR_ADDR_OFS_R2, reg_write, lock))
                remote_two_temp_offset <= reg_wdata; // [RULE9]
            // Only the sense-select and averaging bits live in this block
            if (wr_ok(reg_addr, `THOCR_ADDR_CONFIG2, reg_write, lock))
                fan_sense_averaging_config <= {3'b000, reg_wdata[4:0]}; // [RULE15]
        end
    end

    // Offset correction per channel
    thocr_offset_add u_ofs_r1 (
        .raw_temp       (raw_remote_one),
        .offset         (remote_one_temp_offset),
        .corrected_temp (corr_remote_one)
    ); // [RULE7]
    thocr_offset_add u_ofs_local (
        .raw_temp       (raw_local),
        .offset         (local_temp_offset),
        .corrected_temp (corr_local)
    ); // [RULE8]
    thocr_offset_add u_ofs_r2 (
        .raw_temp       (raw_remote_two),
        .offset         (remote_two_temp_offset),
        .corrected_temp (corr_remote_two)
    ); // [RULE9]

    // The loops see the same corrected value that software reads back
    thocr_hyst_loop u_loop_r1 (
        .clock        (clock),
        .rst          (rst),
        .clock_enable (clock_enable),
        .sample_valid (sample_valid),
        .temp         (corr_remote_one),
        .start_limit  (start_remote_one),
        .crit_limit   (crit_remote_one),
        .hyst         (remote_one_hyst_field),
        .fan_active   (loop_fan[0]),
        .crit_active  (loop_crit[0])
    ); // [RULE2] [RULE16]
    thocr_hyst_loop u_loop_local (
        .clock        (clock),
        .rst          (rst),
        .clock_enable (clock_enable),
        .sample_valid (sample_valid),
        .temp         (corr_local),
        .start_limit  (start_local),
        .crit_limit   (crit_local),
        .hyst         (local_hyst_field),
        .fan_active   (loop_fan[1]),
        .crit_active  (loop_crit[1])
    ); // [RULE1] [RULE16]
    thocr_hyst_loop u_loop_r2 (
        .clock        (clock),
        .rst          (rst),
        .clock_enable (clock_enable),
        .sample_valid (sample_valid),
        .temp         (corr_remote_two),
        .start_limit  (start_remote_two),
        .crit_limit   (crit_remote_two),
        .hyst         (remote_two_hyst_field),
        .fan_active   (loop_fan[2]),
        .crit_active  (loop_crit[2])
    ); // [RULE3] [RULE16]

    // Read mux; unmapped offsets answer zero with no hit
    always @* begin
        next_rdata = 8'h00;
        next_hit   = 1'b1;
        case (reg_addr)
            `THOCR_ADDR_HYST_R1L:   next_rdata = remote_one_local_hysteresis;
            `THOCR_ADDR_HYST_R2:    next_rdata = remote_two_hysteresis;
            `THOCR_ADDR_TREE_TEST:  next_rdata = {7'b000_0000, tree_test_enable_bit};
            `THOCR_ADDR_OFS_R1:     next_rdata = remote_one_temp_offset;
            `THOCR_ADDR_OFS_LOCAL:  next_rdata = local_temp_offset;
            `THOCR_ADDR_OFS_R2:     next_rdata = remote_two_temp_offset;
            `THOCR_ADDR_CONFIG2:    next_rdata = fan_sense_averaging_config;
            default:                next_hit   = 1'b0;
        endcase
    end

    // Registered outputs; one cycle of latency, the loop flags two from the corrected temperature
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata         <= 8'h00;
            reg_hit           <= 1'b0;
            temp_remote_one   <= 8'h00;
            temp_local        <= 8'h00;
            temp_remote_two   <= 8'h00;
            fan_active        <= 3'b000;
            crit_active       <= 3'b000;
            tree_test_mode    <= 1'b0;
            two_wire_sense_en <= 4'h0;
            averaging_off     <= 1'b0;
        end else if (clock_enable) begin
            if (reg_read) begin
                reg_rdata <= next_rdata;
                reg_hit   <= next_hit;
            end
            temp_remote_one <= corr_remote_one; // [RULE16]
            temp_local      <= corr_local; // [RULE16]
            temp_remote_two <= corr_remote_two; // [RULE16]
            fan_active      <= loop_fan;
            crit_active     <= loop_crit;
            tree_test_mode  <= tree_test_enable_bit; // [RULE5]
            // Two-wire sensing is meaningless with high-frequency drive
            two_wire_sense_en <= fan_sense_averaging_config[`THOCR_SENSE_MSB:`THOCR_SENSE_LSB]
                                 & {4{low_freq_mode}}; // [RULE10] [RULE11]
            averaging_off   <= fan_sense_averaging_config[`THOCR_AVG_OFF_BIT]; // [RULE12]
        end
    end
endmodule // thocr_regs

// ===== tb/thocr_regs_assertions.sv
// Checker for the hysteresis / offset / config register group ports.
// Assumes one clock domain and the byte register port of the hand-over.
`timescale 1ns/1ps
module thocr_chk (
    input wire       clock,
    input wire       rst,
    input wire       clock_enable,
    input wire       lock,
    input wire       low_freq_mode,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       reg_hit,
    input wire       sample_valid,
    input wire [7:0] raw_remote_one,
    input wire [7:0] raw_local,
    input wire [7:0] temp_remote_one,
    input wire [7:0] temp_local,
    input wire [7:0] start_local,
    input wire [7:0] crit_remote_one,
    input wire [2:0] fan_active,
    input wire [2:0] crit_active,
    input wire       tree_test_mode,
    input wire       averaging_off,
    input wire [3:0] two_wire_sense_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Map check: only 0x6D..0x73 answer
    a_read_hit_map: assert property (clock_enable && reg_read |=> reg_hit ==
        ($past(reg_addr) >= 8'h6d && $past(reg_addr) <= 8'h73)) else $error("hit wrong");
    a_unmapped_zero: assert property (clock_enable && reg_read &&
        (reg_addr < 8'h6d || reg_addr > 8'h73) |=> reg_rdata == 8'h00) else $error("rdata");
    a_tree_bit_follows: assert property ((clock_enable && reg_write && !lock &&
        reg_addr == 8'h6f) ##1 clock_enable |=> tree_test_mode == $past(reg_wdata[0], 2))
        else $error("tree bit");
    a_avg_bit_follows: assert property ((clock_enable && reg_write && !lock &&
        reg_addr == 8'h73) ##1 clock_enable |=> averaging_off == $past(reg_wdata[4], 2))
        else $error("avg bit");
    // Allow two cycles for a write taken just before lock rose
    a_lock_freezes_cfg: assert property (lock && $past(lock) && $past(lock, 2) |->
        $stable(averaging_off) && $stable(tree_test_mode)) else $error("locked change");
    a_sense_needs_lfm: assert property (!$past(low_freq_mode) |->
        two_wire_sense_en == 4'h0) else $error("sense not gated");
    a_fan_above_start: assert property ((clock_enable && sample_valid &&
        temp_local > start_local && $stable(temp_local))[*3] |=> fan_active[1])
        else $error("fan not set");
    a_crit_above_limit: assert property ((clock_enable && sample_valid &&
        temp_remote_one > crit_remote_one && $stable(temp_remote_one))[*3] |=>
        crit_active[0]) else $error("crit not set");
endmodule // thocr_chk

// ===== tb/thocr_host.sv
// Host model issuing byte writes and reads on the register port.
// Assumes the device takes a strobe at the rising edge of clock.
`timescale 1ns/1ps
module thocr_host (
    input  wire       clock,
    output reg        reg_write,
    output reg        reg_read,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata
);
    initial begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // Idle bus shows inverted values so stale data never looks valid
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_write <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= (a == 8'h6f) ? (d & 8'h01) : d;
            @(posedge clock);
            reg_write <= 1'b0;
            reg_addr  <= ~a;
            reg_wdata <= ~d;
        end
    endtask
    // Data is valid after the edge that takes the strobe
    task rd(input [7:0] a);
        begin
            @(posedge clock);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge clock);
            reg_read <= 1'b0;
            reg_addr <= ~a;
        end
    endtask
endmodule // thocr_host

// ===== tb/tb_top.sv
// Testbench for the register group: resets, then register and loop tests.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module tb_top;
    reg        clock = 1'b0, rst = 1'b1, lock = 1'b0, lfm = 1'b1, ce = 1'b1;
    reg  [7:0] r1 = 8'h50, rl = 8'h50, r2 = 8'h10;
    reg  [7:0] s1 = 8'h00, sl = 8'h00, s2 = 8'h00, c1 = 8'h00, cl = 8'h00, c2 = 8'h00;
    wire       wr_s, rd_s, hit, tree, averaging_disable_bit;
    wire [7:0] addr, wdata, rdata, t1, tl, t2;
    wire [2:0] fan, crit;
    wire [3:0] sense;
    integer    n_fail = 0, checks = 0, i;
    // Written values per offset 0x6D..0x73
    localparam [55:0] WV = 56'hA5_B701_04FE_80FF;
    thocr_host host_u (.clock(clock), .reg_write(wr_s), .reg_read(rd_s), .reg_addr(addr),
        .reg_wdata(wdata));
    thocr_regs dut_u (.clock(clock), .rst(rst), .clock_enable(ce), .lock(lock),
        .low_freq_mode(lfm), .reg_write(wr_s), .reg_read(rd_s), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .sample_valid(1'b1),
        .raw_remote_one(r1), .raw_local(rl), .raw_remote_two(r2), .start_remote_one(s1),
        .start_local(sl), .start_remote_two(s2), .crit_remote_one(c1), .crit_local(cl),
        .crit_remote_two(c2), .temp_remote_one(t1), .temp_local(tl), .temp_remote_two(t2),
        .fan_active(fan), .crit_active(crit), .tree_test_mode(tree),
        .two_wire_sense_en(sense), .averaging_off(averaging_disable_bit));
    initial forever #25 clock = ~clock;
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // Read and compare data and map flag
    task rdc(input [7:0] a, input [7:0] e);
        begin
            host_u.rd(a);
            @(negedge clock);
            chk("rdata", e, rdata);
            chk("hit", {7'h00, a >= 8'h6d && a <= 8'h73}, {7'h00, hit});
        end
    endtask
    // Loop outputs need two edges; four leaves margin
    task step(input [23:0] raws, input [5:0] e);
        begin
            @(posedge clock);
            {r1, rl, r2} <= raws;
            repeat (4) @(posedge clock);
            @(negedge clock);
            chk("fan", {5'h00, e[5:3]}, {5'h00, fan});
            chk("crit", {5'h00, e[2:0]}, {5'h00, crit});
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 7; i = i + 1)
            rdc(i[7:0] + 8'h6d, (i == 0) ? 8'h44 : (i == 1) ? 8'h40 : 8'h00);
        for (i = 0; i < 7; i = i + 1)
            host_u.wr(i[7:0] + 8'h6d, WV[8*(6-i) +: 8]);
        for (i = 0; i < 7; i = i + 1)
            rdc(i[7:0] + 8'h6d, WV[8*(6-i) +: 8] & ((i == 1) ? 8'hf0 : (i == 6) ? 8'h1f :
                8'hff));
        chk("tree", 8'h01, {7'h00, tree});
        chk("avg", 8'h01, {7'h00, averaging_disable_bit});
        chk("sense", 8'h0f, {4'h0, sense});
        chk("t1", 8'h54, t1);
        chk("tl", 8'h4e, tl);
        chk("t2", 8'h00, t2);
        @(posedge clock);
        lfm <= 1'b0;
        r1 <= 8'hfe;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("sense", 8'h00, {4'h0, sense});
        chk("t1", 8'hff, t1);
        rdc(8'h74, 8'h00);
        // Locked writes must leave old contents
        @(posedge clock);
        lock <= 1'b1;
        host_u.wr(8'h6d, 8'h00);
        host_u.wr(8'h73, 8'h00);
        rdc(8'h6d, 8'ha5);
        chk("avg", 8'h01, {7'h00, averaging_disable_bit});
        @(posedge clock);
        lock <= 1'b0;
        host_u.wr(8'h6f, 8'h00);
        host_u.wr(8'h73, 8'h00);
        // The output copy of the config bit follows one edge after the write
        @(posedge clock);
        @(negedge clock);
        chk("tree", 8'h00, {7'h00, tree});
        chk("avg", 8'h00, {7'h00, averaging_disable_bit});
        host_u.wr(8'h6d, 8'h35);
        host_u.wr(8'h6e, 8'h20);
        for (i = 0; i < 3; i = i + 1)
            host_u.wr(i[7:0] + 8'h70, 8'h00);
        {s1, sl, s2, c1, cl, c2} <= 48'hff60_4070_ffff;
        step(24'h7162_41, 6'b110_001);
        step(24'h6a57_3d, 6'b110_001);
        step(24'h6956_3c, 6'b000_000);
        // Raw local stays below start; only the offset lifts it above
        host_u.wr(8'h71, 8'h0c);
        step(24'h6956_3c, 6'b010_000);
        chk("tl", 8'h62, tl);
        // A write offered while the clock enable is low must not land
        @(posedge clock);
        ce <= 1'b0;
        host_u.wr(8'h71, 8'h00);
        ce <= 1'b1;
        rdc(8'h71, 8'h0c);
        complete_run;
    end
endmodule // tb_top
bind thocr_regs thocr_chk chk_u (.*);
